// ### hdl/irq_front_pkg.sv
// Constants, carrier types and state layout of the interrupt controller front end
package irq_front_pkg;

  localparam int          NUM_INPUTS    = 24;
  localparam logic [7:0]  MAX_ENTRY     = 8'h17;
  localparam logic [4:0]  LAST_INPUT    = 5'h17;

  // Direct register byte addresses
  localparam logic [7:0]  ADDR_SELECT   = 8'h00;
  localparam logic [7:0]  ADDR_WINDOW   = 8'h10;
  localparam logic [7:0]  ADDR_VASSERT  = 8'h20;
  localparam logic [7:0]  ADDR_EOI      = 8'h40;

  // Indirect register indices
  localparam logic [7:0]  IDX_IDENTITY  = 8'h00;
  localparam logic [7:0]  IDX_VERSION   = 8'h01;
  localparam logic [7:0]  IDX_ARB       = 8'h02;
  localparam logic [7:0]  IDX_REDIR     = 8'h10;
  localparam logic [7:0]  IDX_REDIR_END = 8'h40;

  // Identity register fields
  localparam int          ID_LSB        = 24;
  localparam int          DT_BIT        = 15;
  localparam int          LTS_BIT       = 14;
  localparam logic [31:0] ID_WMASK      = 32'h0f00c000;
  localparam logic [31:0] ID_RST        = 32'h00000000;

  // Version register fields
  localparam int          MAXE_LSB      = 16;
  localparam int          PRQ_BIT       = 15;

  // Redirection entry fields
  localparam int          VEC_LSB       = 0;
  localparam int          DMODE_LSB     = 8;
  localparam int          DSTMODE_BIT   = 11;
  localparam int          DSTAT_BIT     = 12;
  localparam int          POL_BIT       = 13;
  localparam int          RPEND_BIT     = 14;
  localparam int          TRIG_BIT      = 15;
  localparam int          MASK_BIT      = 16;
  localparam int          DEST_LSB      = 24;
  localparam logic [31:0] LO_WMASK      = 32'h0001afff;
  localparam logic [31:0] HI_WMASK      = 32'hff000000;
  localparam logic [31:0] LO_RST        = 32'h00010000;
  localparam logic [31:0] HI_RST        = 32'h00000000;
  localparam logic [7:0]  SELECT_RST    = 8'h00;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic [4:0] entry;
    logic [7:0] vector;
    logic [7:0] dest;
    logic [2:0] dmode;
    logic       dest_logical;
    logic       level;
    logic       deassert;
  } irq_msg_t;

  typedef struct packed {
    logic [7:0]                   select;
    logic [31:0]                  identity;
    logic [NUM_INPUTS-1:0][31:0]  redir_lo;
    logic [NUM_INPUTS-1:0][31:0]  redir_hi;
    logic [NUM_INPUTS-1:0]        pending;
    logic [NUM_INPUTS-1:0]        remote_pending_flag;
    logic [NUM_INPUTS-1:0]        deassert_pend;
    logic [NUM_INPUTS-1:0]        active_prev;
    logic                         busy;
    irq_msg_t                     msg;
    logic                         ack;
    logic [31:0]                  rdata;
  } state_t;

  localparam state_t STATE_RST = '{
    select:   SELECT_RST,
    identity: ID_RST,
    redir_lo: {NUM_INPUTS{LO_RST}},
    redir_hi: {NUM_INPUTS{HI_RST}},
    default:  '0
  };

endpackage : irq_front_pkg

// ### hdl/irq_front_end.sv
// Register front end and redirection logic of the I/O interrupt controller
`timescale 1ns/10ps
`default_nettype none

module irq_front_end
  import irq_front_pkg::*;
#(
  parameter logic [7:0] IMPL_VERSION = 8'h11  // Arbitrary value
) (
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rst_b,
  input  wire mem_req_t              i_req,
  input  wire logic [NUM_INPUTS-1:0] i_irq_pins,
  input  wire logic                  i_msg_ack,
  output logic                       o_ack,
  output logic [31:0]                o_rdata,
  output logic                       o_msg_valid,
  output irq_msg_t                   o_msg,
  output logic [3:0]                 o_arb_id,
  output logic                       o_delivery_type
);

  localparam logic [31:0] VERSION_WORD =
    {8'h00, MAX_ENTRY, 1'b1, 7'h00, IMPL_VERSION};

  state_t q;
  state_t d;

  logic                  in_redir;
  logic [4:0]            sel_entry;
  logic                  sel_hi;
  logic [31:0]           ind_rd;
  logic [31:0]           lane_mask;
  logic [NUM_INPUTS-1:0] vassert;
  logic [NUM_INPUTS-1:0] eoi_hit;
  logic [NUM_INPUTS-1:0] active;
  logic [NUM_INPUTS-1:0] inflight;
  logic [NUM_INPUTS-1:0] level_mode;
  logic [NUM_INPUTS-1:0] masked;
  logic                  wr_window;
  logic                  wr_vassert;
  logic                  wr_eoi;
  logic                  pick_found;
  logic [4:0]            pick;
  logic                  launch;

  assign o_ack           = q.ack;
  assign o_rdata         = q.rdata;
  assign o_msg_valid     = q.busy;
  assign o_msg           = q.msg;
  assign o_arb_id        = q.identity[ID_LSB +: 4];
  assign o_delivery_type = q.identity[DT_BIT];

  // Indirect decode of the select register
  assign in_redir  = (q.select >= IDX_REDIR) && (q.select < IDX_REDIR_END);
  assign sel_entry = 5'((q.select - IDX_REDIR) >> 1);
  assign sel_hi    = q.select[0];

  assign wr_window  = i_req.valid && i_req.write && (i_req.addr == ADDR_WINDOW);
  assign wr_vassert = i_req.valid && i_req.write && (i_req.addr == ADDR_VASSERT);
  assign wr_eoi     = i_req.valid && i_req.write && (i_req.addr == ADDR_EOI);

  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign lane_mask[b*8 +: 8] = {8{i_req.be[b]}};
  end

  for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_entry
    assign active[i]     = i_irq_pins[i] ^ q.redir_lo[i][POL_BIT];
    assign level_mode[i] = q.redir_lo[i][TRIG_BIT];
    assign masked[i]     = q.redir_lo[i][MASK_BIT];
    assign inflight[i]   = q.busy && (q.msg.entry == 5'(i));
    // Only the low five bits choose the input; numbers above 23 match nothing
    assign vassert[i]    = wr_vassert && (i_req.wdata[4:0] == 5'(i))
                           && (i_req.wdata[4:0] <= LAST_INPUT);
    assign eoi_hit[i]    = wr_eoi && (i_req.wdata[7:0] == q.redir_lo[i][VEC_LSB +: 8]);
  end

  // Current value of the selected indirect register
  always_comb begin
    ind_rd = 32'h00000000;
    if (in_redir && sel_entry <= LAST_INPUT) begin
      if (sel_hi) begin
        ind_rd = q.redir_hi[sel_entry] & HI_WMASK;
      end else begin
        ind_rd = q.redir_lo[sel_entry] & LO_WMASK;
        ind_rd[DSTAT_BIT] = inflight[sel_entry];
        ind_rd[RPEND_BIT] = q.remote_pending_flag[sel_entry];
      end
    end else if (q.select == IDX_IDENTITY) begin
      ind_rd = q.identity & ID_WMASK;
    end else if (q.select == IDX_VERSION) begin
      ind_rd = VERSION_WORD;
    end else if (q.select == IDX_ARB) begin
      ind_rd = {4'h0, q.identity[ID_LSB +: 4], 24'h000000};
    end
  end

  // Lowest-numbered entry with work waiting wins the message channel
  always_comb begin
    pick_found = 1'b0;
    pick       = 5'h00;
    for (int i = NUM_INPUTS - 1; i >= 0; i--) begin
      if (q.pending[i] || q.deassert_pend[i]) begin
        pick_found = 1'b1;
        pick       = 5'(i);
      end
    end
  end

  // Channel grant this cycle; the granted entry is not in inflight until the next cycle
  assign launch = !q.busy && pick_found;

  always_comb begin
    d       = q;
    d.ack   = 1'b0;
    d.rdata = 32'h00000000;

    // Register port; every access is answered one cycle later
    if (i_req.valid) begin
      d.ack = 1'b1;
      if (i_req.write) begin
        if (i_req.addr == ADDR_SELECT && i_req.be[0]) begin
          d.select = i_req.wdata[7:0];
        end else if (wr_window) begin
          if (q.select == IDX_IDENTITY) begin
            d.identity = (q.identity & ~(ID_WMASK & lane_mask))
                         | (i_req.wdata & ID_WMASK & lane_mask);
          end else if (in_redir && sel_entry <= LAST_INPUT) begin
            if (sel_hi) begin
              d.redir_hi[sel_entry] = (q.redir_hi[sel_entry] & ~(HI_WMASK & lane_mask))
                                      | (i_req.wdata & HI_WMASK & lane_mask);
            end else begin
              d.redir_lo[sel_entry] = (q.redir_lo[sel_entry] & ~(LO_WMASK & lane_mask))
                                      | (i_req.wdata & LO_WMASK & lane_mask);
            end
          end
        end
      end else begin
        unique case (i_req.addr)
          ADDR_SELECT: d.rdata = {24'h000000, q.select};
          ADDR_WINDOW: d.rdata = ind_rd & lane_mask;
          default:     d.rdata = 32'h00000000;
        endcase
      end
    end

    // Completed message: level assertions, not deasserts, now wait for end of interrupt
    if (q.busy && i_msg_ack) begin
      d.busy = 1'b0;
      if (q.msg.level && !q.msg.deassert) begin
        d.remote_pending_flag[q.msg.entry] = 1'b1;
      end
    end

    // Sets before clears; an end of interrupt in the cycle its remote pending is set is dropped
    for (int i = 0; i < NUM_INPUTS; i++) begin
      if (eoi_hit[i] && !(q.busy && i_msg_ack && q.msg.entry == 5'(i) && q.msg.level
                          && !q.msg.deassert)) begin
        d.remote_pending_flag[i] = 1'b0;
      end
      if (masked[i]) begin
        d.pending[i] = 1'b0;
      end
    end

    if (!q.busy && pick_found) begin
      d.busy              = 1'b1;
      d.msg.entry         = pick;
      d.msg.vector        = q.redir_lo[pick][VEC_LSB +: 8];
      d.msg.dest          = q.redir_hi[pick][DEST_LSB +: 8];
      d.msg.dmode         = q.redir_lo[pick][DMODE_LSB +: 3];
      d.msg.dest_logical  = q.redir_lo[pick][DSTMODE_BIT];
      d.msg.level         = level_mode[pick];
      // A deassert waiting on the picked entry goes out ahead of that entry's new assertion
      d.msg.deassert      = q.deassert_pend[pick];
      if (q.deassert_pend[pick]) begin
        d.deassert_pend[pick] = 1'b0;
      end else begin
        d.pending[pick] = 1'b0;
      end
    end

    for (int i = 0; i < NUM_INPUTS; i++) begin
      d.active_prev[i] = active[i];
      if (!masked[i]) begin
        if (!level_mode[i]) begin
          if ((active[i] && !q.active_prev[i]) || vassert[i]) begin
            d.pending[i] = 1'b1;
          end
        end else if ((active[i] || vassert[i]) && !q.remote_pending_flag[i]
                     && !inflight[i] && !(launch && pick == 5'(i))) begin
          // Without the launch term a level entry would be sent twice
          d.pending[i] = 1'b1;
        end
      end
      if (q.identity[LTS_BIT] && q.identity[DT_BIT] && level_mode[i]
          && q.remote_pending_flag[i] && q.active_prev[i] && !active[i]) begin
        d.deassert_pend[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  // Checks
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_write(logic [7:0] a);
    i_req.valid && i_req.write && i_req.addr == a;
  endsequence

  sequence s_read(logic [7:0] a);
    i_req.valid && !i_req.write && i_req.addr == a;
  endsequence

  // Message of entry e taken by the consumer this cycle
  sequence s_msg_taken(int e);
    q.busy && i_msg_ack && q.msg.entry == 5'(e);
  endsequence

  a_select_load: assert property (s_write(ADDR_SELECT) ##0 i_req.be[0]
    |=> q.select == $past(i_req.wdata[7:0]))
    else $error("Select register did not load");

  a_select_read: assert property (s_read(ADDR_SELECT)
    |=> o_rdata == {24'h000000, $past(q.select)})
    else $error("Select register read wrong");

  a_ack_one: assert property (i_req.valid |=> o_ack)
    else $error("Request not answered");

  a_idle_quiet: assert property (!i_req.valid |=> !o_ack && o_rdata == 32'h00000000)
    else $error("Answer without request");

  a_version_read: assert property (s_read(ADDR_WINDOW) ##0 (q.select == IDX_VERSION
    && i_req.be == 4'hf) |=> o_ack && o_rdata == VERSION_WORD)
    else $error("Version word read wrong");

  a_arb_follow: assert property (s_write(ADDR_WINDOW) ##0 (q.select == IDX_IDENTITY
    && i_req.be[3]) |=> o_arb_id == $past(i_req.wdata[27:24]))
    else $error("Arbitration id did not follow identity");

  a_byte_lane: assert property (s_write(ADDR_WINDOW) ##0 (q.select == IDX_IDENTITY
    && !i_req.be[3]) |=> $stable(o_arb_id))
    else $error("Unselected byte lane changed");

  a_lane_guard: assert property (s_write(ADDR_WINDOW) ##0 (q.select == IDX_IDENTITY
    && !i_req.be[1]) |=> $stable(o_delivery_type))
    else $error("Delivery type changed by other lane");

  a_vassert_range: assert property (s_write(ADDR_VASSERT) ##0
    (i_req.wdata[4:0] > LAST_INPUT) |-> vassert == '0)
    else $error("Out of range virtual input asserted");

  a_msg_stands: assert property (o_msg_valid && !i_msg_ack
    |=> o_msg_valid && $stable(o_msg))
    else $error("Message withdrawn before taken");

  a_wo_read_zero: assert property ((s_read(ADDR_VASSERT) or s_read(ADDR_EOI))
    |=> o_ack && o_rdata == 32'h00000000 && $stable(q.pending))
    else $error("Write-only port read not zero");

  for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_chk
    a_vassert_sets: assert property (vassert[i] && !masked[i] && !level_mode[i]
      |=> q.pending[i])
      else $error("Virtual assertion lost");

    a_eoi_clears: assert property (eoi_hit[i] && !(q.busy && i_msg_ack)
      |=> !q.remote_pending_flag[i])
      else $error("End of interrupt did not clear remote pending");

    // Same-cycle set and clear: the set wins
    a_eoi_set_wins: assert property (s_msg_taken(i) ##0 (eoi_hit[i] && q.msg.level
      && !q.msg.deassert) |=> q.remote_pending_flag[i])
      else $error("Remote pending set lost to clear");

    a_deassert_keeps: assert property (s_msg_taken(i) ##0 (q.msg.deassert && !eoi_hit[i])
      |=> q.remote_pending_flag[i] == $past(q.remote_pending_flag[i]))
      else $error("Deassert message changed remote pending");

    a_level_no_repend: assert property (level_mode[i] && q.remote_pending_flag[i]
      && !q.pending[i] |=> !q.pending[i])
      else $error("Level entry pended while remote pending");

    a_mask_no_pend: assert property (masked[i] ##1 masked[i] |-> !q.pending[i])
      else $error("Masked entry held pending");

    a_level_reissue: assert property (level_mode[i] && !masked[i] && active[i]
      && !q.remote_pending_flag[i] && !inflight[i] |=> q.pending[i] || inflight[i])
      else $error("Active level input not reissued");

    a_deassert_gate: assert property ($rose(q.deassert_pend[i])
      |-> $past(q.identity[LTS_BIT] && q.identity[DT_BIT] && level_mode[i]))
      else $error("Deassert without enable");
  end

endmodule : irq_front_end

`default_nettype wire

// ### tb/msg_sink.sv
// Message consumer model standing on the delivery side of the controller
`timescale 1ns/10ps
`default_nettype none

module msg_sink
  import irq_front_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_msg_valid,
  input  wire irq_msg_t   i_msg,
  input  wire logic [3:0] i_delay,
  output logic            o_msg_ack
);
  irq_msg_t   got[$];
  logic [3:0] wait_cnt;

  initial o_msg_ack = 1'b0;

  // Acks just after the edge; message captured while it still stands
  always @(posedge i_core_clk) begin
    #1;
    if (!i_rst_b) begin
      o_msg_ack = 1'b0;
      wait_cnt  = 4'h0;
    end else if (o_msg_ack) begin
      o_msg_ack = 1'b0;
    end else if (i_msg_valid && wait_cnt == i_delay) begin
      o_msg_ack = 1'b1;
      got.push_back(i_msg);
      wait_cnt  = 4'h0;
    end else if (i_msg_valid) begin
      wait_cnt  = wait_cnt + 4'h1;
    end
  end
endmodule : msg_sink

`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the interrupt controller register front end
`timescale 1ns/10ps
`default_nettype none

module testbench
  import irq_front_pkg::*;
;
  localparam logic [7:0] VER = 8'h5a;  // Arbitrary value
  logic                  i_core_clk;
  logic                  i_rst_b;
  mem_req_t              req;
  logic [NUM_INPUTS-1:0] pins;
  logic                  msg_ack;
  logic                  ack;
  logic [31:0]           rdata;
  logic                  msg_valid;
  irq_msg_t              msg;
  logic [3:0]            arb_id;
  logic                  dtype;
  logic [3:0]            sink_delay;
  int                    n_mismatch;
  int                    checks_done;

  irq_front_end #(.IMPL_VERSION(VER)) irq_front_end_i (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_req(req), .i_irq_pins(pins),
    .i_msg_ack(msg_ack), .o_ack(ack), .o_rdata(rdata), .o_msg_valid(msg_valid),
    .o_msg(msg), .o_arb_id(arb_id), .o_delivery_type(dtype));

  msg_sink msg_sink_i (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_msg_valid(msg_valid),
    .i_msg(msg), .i_delay(sink_delay), .o_msg_ack(msg_ack));

  initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Request held for one taking edge; answer read while it stands
  task automatic bus(input logic wr, input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge i_core_clk);
    #1;
    req = '{valid: 1'b1, write: wr, addr: a, be: be, wdata: wd};
    @(posedge i_core_clk);
    #1;
    req.valid = 1'b0;
    rd = rdata;
    check(ack, 1'b1);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    logic [31:0] rd;
    bus(1'b1, a, be, d, rd);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] got;
    bus(1'b0, a, 4'hf, 32'h0, got);
    check(got, exp);
  endtask : rd

  task automatic ind_wr(input logic [7:0] idx, input logic [31:0] d);
    wr(ADDR_SELECT, 4'h1, {24'h0, idx});
    wr(ADDR_WINDOW, 4'hf, d);
  endtask : ind_wr

  task automatic ind_rd(input logic [7:0] idx, input logic [31:0] exp);
    wr(ADDR_SELECT, 4'h1, {24'h0, idx});
    rd(ADDR_WINDOW, exp);
  endtask : ind_rd

  task automatic wait_msgs(input int n);
    for (int k = 0; k < 60 && msg_sink_i.got.size() < n; k++) @(posedge i_core_clk);
    check(msg_sink_i.got.size(), n);
  endtask : wait_msgs

  task automatic t_reset;
    ind_rd(IDX_IDENTITY, 32'h0);
    ind_rd(IDX_VERSION, {8'h00, MAX_ENTRY, 1'b1, 7'h00, VER});
    ind_rd(IDX_ARB, 32'h0);
    ind_rd(8'h3e, LO_RST);
    rd(ADDR_SELECT, 32'h3e);
    rd(8'h30, 32'h0);
    rd(ADDR_VASSERT, 32'h0);
    rd(ADDR_EOI, 32'h0);
  endtask : t_reset

  task automatic t_identity;
    ind_wr(IDX_IDENTITY, 32'hffffffff);
    ind_rd(IDX_IDENTITY, 32'h0f00c000);
    check(arb_id, 4'hf);
    check(dtype, 1'b1);
    ind_wr(IDX_IDENTITY, 32'h0500c000);
    ind_rd(IDX_ARB, 32'h05000000);
    ind_wr(IDX_VERSION, 32'h0);
    ind_rd(IDX_VERSION, {8'h00, MAX_ENTRY, 1'b1, 7'h00, VER});
  endtask : t_identity

  task automatic t_bytes;
    wr(ADDR_SELECT, 4'h1, 32'h12);
    wr(ADDR_WINDOW, 4'h1, 32'h88888877);
    rd(ADDR_WINDOW, 32'h00010077);
    wr(ADDR_WINDOW, 4'h4, 32'h00fe0000);
    rd(ADDR_WINDOW, 32'h00000077);
  endtask : t_bytes

  task automatic t_vassert;
    msg_sink_i.got.delete();
    sink_delay = 4'h0;
    pins[0] = 1'b1;
    ind_wr(8'h1a, 32'h00000035);
    wr(ADDR_VASSERT, 4'hf, 32'hffffffe5);
    wait_msgs(1);
    check(msg_sink_i.got[0].entry, 5'h05);
    check(msg_sink_i.got[0].vector, 8'h35);
    check(msg_sink_i.got[0].level, 1'b0);
    wr(ADDR_VASSERT, 4'hf, 32'h00000018);
    repeat (10) @(posedge i_core_clk);
    check(msg_sink_i.got.size(), 1);
    pins[0] = 1'b0;
  endtask : t_vassert

  task automatic t_eoi;
    msg_sink_i.got.delete();
    sink_delay = 4'h3;
    ind_wr(8'h12, 32'h00008050);
    ind_wr(8'h14, 32'h00008050);
    pins[2:1] = 2'b11;
    wait_msgs(2);
    check(msg_sink_i.got[0].entry, 5'h01);
    check(msg_sink_i.got[1].entry, 5'h02);
    check(msg_sink_i.got[1].level, 1'b1);
    ind_rd(8'h14, 32'h0000c050);
    pins[2] = 1'b0;
    wait_msgs(3);
    check(msg_sink_i.got[2].entry, 5'h02);
    check(msg_sink_i.got[2].deassert, 1'b1);
    wr(ADDR_EOI, 4'hf, 32'h00000150);
    ind_rd(8'h14, 32'h00008050);
    wait_msgs(4);
    check(msg_sink_i.got[3].entry, 5'h01);
    check(msg_sink_i.got[3].deassert, 1'b0);
  endtask : t_eoi

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  initial begin
    repeat (20000) @(posedge i_core_clk);
    n_mismatch++;
    summarize();
  end

  initial begin
    n_mismatch  = 0;
    checks_done = 0;
    i_rst_b     = 1'b0;
    req         = '0;
    pins        = '0;
    sink_delay  = 4'h0;
    repeat (8) @(posedge i_core_clk);
    #1;
    i_rst_b = 1'b1;
    t_reset();
    t_identity();
    t_bytes();
    t_vassert();
    t_eoi();
    summarize();
  end
endmodule : testbench

`default_nettype wire
